// *** logic/video_convert_ctrl_irq_regs.sv ***
// Function
// [RQ1] Start bit launches one frame; reads 1 while busy, 0 when idle
// [RQ2] Start bit cannot be altered while busy; only 0 to 1 launches
// [RQ3] Chroma enable sampled at start; 0 means no chroma processing
// [RQ4] Luma enable sampled at start; 0 means no luma processing
// [RQ5] Software enables luma or chroma, and top or bottom field
// [RQ6] Field enables act only in interlaced processing
// [RQ7] Two-bit mode picks edge pad, trans-code, pre-codec, post-codec
// [RQ8] Menu overlay enable acts only in modes 1h and 3h
// [RQ9] Range mapping enable acts only in trans-code or post-codec
// [RQ10] Resize enable acts in every mode except mode 0
// [RQ11] Horizontal chroma conversion gated by bit; vertical follows mode
// [RQ12] Software never enables resize and menu overlay together
// [RQ13] Bit 12 selects interlaced per-field or progressive frame work
// [RQ14] Bits 15..13 pick field or frame storage for three buffers
// [RQ15] Software supplies overlay source in progressive form
// [RQ16] Software writes enable first, then arms the interrupt
// [RQ17] Arm bit takes only ones, held 0 while enable is 0
// [RQ18] Armed engine pulses the interrupt once per finished frame
// [RQ19] Disarm write clears arm only when enable and arm are 1
// [RQ20] Status reads 0 during a frame, 1 once done and unchecked
// [RQ21] Writing 1 to status clear zeroes status; reads back 0
// [RQ22] Frame end drops start bit and raises status in one cycle
`default_nettype none
module video_convert_ctrl_irq_regs
  import video_convert_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  output logic pready,
  output logic [DATA_W-1:0] prdata,
  output logic pslverr,
  // Datapath handshake
  input wire logic frame_finished,
  output logic frame_launch,
  // Frame configuration held for the datapath
  output logic luma_proc_act,
  output logic chroma_proc_act,
  output logic top_field_act,
  output logic bottom_field_act,
  output logic [1:0] flow_mode_act,
  output logic resize_act,
  output logic range_map_act,
  output logic chroma_conv_h_act,
  output logic chroma_conv_v_act,
  output logic menu_overlay_act,
  output logic progressive_act,
  output logic overlay_src_fmt_act,
  output logic video_src_fmt_act,
  output logic result_fmt_act,
  // Interrupt
  output logic irq_pulse
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic reg_mapped(input logic [ADDR_W-1:0] a);
    reg_mapped = (a == OFS_ENGINE_CONTROL) || (a == OFS_IRQ_ENABLE) ||
                 (a == OFS_IRQ_ARM_SET) || (a == OFS_IRQ_ARM_CLEAR) ||
                 (a == OFS_IRQ_FRAME_STATUS) ||
                 (a == OFS_IRQ_STATUS_CLEAR);
  endfunction : reg_mapped

  // Trans-code and post-codec share the odd codes
  function automatic logic mode_odd(input logic [1:0] m);
    mode_odd = (m == FLOW_TRANS_CODE) || (m == FLOW_POST_CODEC);
  endfunction : mode_odd

  function automatic logic mode_active(input logic [1:0] m);
    mode_active = (m != FLOW_EDGE_PAD);
  endfunction : mode_active

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  engine_state_t state;
  logic [15:0] ctrl_cfg;
  logic irq_enable_bit;
  logic irq_arm_bit;
  logic frame_done_flag;
  logic busy;
  logic setup_phase;
  logic access_done;
  logic wr_en;
  logic wr_ctrl;
  logic wr_enable;
  logic wr_arm;
  logic wr_disarm;
  logic wr_stclr;
  logic launch;
  logic done_evt;
  logic [1:0] wmode;
  logic [DATA_W-1:0] next_prdata;

  assign busy = (state != ENG_IDLE);
  assign setup_phase = psel & ~penable;
  assign access_done = psel & penable & pready;
  assign wr_en = access_done & pwrite;
  assign wr_ctrl = wr_en & (paddr == OFS_ENGINE_CONTROL);
  assign wr_enable = wr_en & (paddr == OFS_IRQ_ENABLE);
  assign wr_arm = wr_en & (paddr == OFS_IRQ_ARM_SET);
  assign wr_disarm = wr_en & (paddr == OFS_IRQ_ARM_CLEAR);
  assign wr_stclr = wr_en & (paddr == OFS_IRQ_STATUS_CLEAR);
  assign wmode = pwdata[BIT_MODE_HI:BIT_MODE_LO];
  // Only an idle engine accepts a start; busy writes leave it alone
  assign launch = wr_ctrl & pwdata[BIT_FRAME_START] & ~busy; // see [RQ2]
  assign done_evt = (state == ENG_RUN) & frame_finished;

  // ----------------------------------------------------------------
  // APB response
  // ----------------------------------------------------------------
  // Zero wait: ready and read data are flopped at the setup edge
  always_comb begin
    next_prdata = READ_ZERO;
    unique case (paddr)
      OFS_ENGINE_CONTROL:
        next_prdata = {16'h0000, ctrl_cfg | {15'h0000, busy}}; // see [RQ1]
      OFS_IRQ_ENABLE:
        next_prdata = {31'h0000_0000, irq_enable_bit};
      OFS_IRQ_ARM_SET:
        next_prdata = {31'h0000_0000, irq_arm_bit};
      OFS_IRQ_FRAME_STATUS:
        next_prdata = {31'h0000_0000, frame_done_flag}; // see [RQ20]
      // Clear registers are write-only and read as zero
      default:
        next_prdata = READ_ZERO; // see [RQ21]
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= READ_ZERO;
    end else begin
      pready <= setup_phase;
      pslverr <= setup_phase & ~reg_mapped(paddr);
      if (setup_phase && !pwrite) begin
        prdata <= next_prdata;
      end else if (setup_phase) begin
        prdata <= READ_ZERO;
      end
    end
  end

  // ----------------------------------------------------------------
  // Frame engine sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ENG_IDLE;
    end else begin
      unique case (state)
        ENG_IDLE: begin
          if (launch) begin
            state <= ENG_LAUNCH; // see [RQ1]
          end
        end
        ENG_LAUNCH: state <= ENG_RUN;
        ENG_RUN: begin
          if (frame_finished) begin
            state <= ENG_IDLE; // see [RQ22]
          end
        end
        default: state <= ENG_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_launch <= 1'b0;
    end else begin
      frame_launch <= launch; // see [RQ1]
    end
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  // Still writable mid-frame; the frame runs on its launch copy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_cfg <= CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_cfg <= pwdata[15:0] & CTRL_CFG_MASK;
    end
  end

  // ----------------------------------------------------------------
  // Frame configuration captured on the start edge
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      luma_proc_act <= 1'b0;
      chroma_proc_act <= 1'b0;
      flow_mode_act <= FLOW_EDGE_PAD;
    end else if (launch) begin
      luma_proc_act <= pwdata[BIT_LUMA_PROC]; // see [RQ4]
      chroma_proc_act <= pwdata[BIT_CHROMA_PROC]; // see [RQ3]
      flow_mode_act <= wmode; // see [RQ7]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      top_field_act <= 1'b0;
      bottom_field_act <= 1'b0;
      progressive_act <= 1'b0;
    end else if (launch) begin
      progressive_act <= pwdata[BIT_PROGRESSIVE]; // see [RQ13]
      top_field_act <= pwdata[BIT_TOP_FIELD] &
                       ~pwdata[BIT_PROGRESSIVE]; // see [RQ6]
      bottom_field_act <= pwdata[BIT_BOTTOM_FIELD] &
                          ~pwdata[BIT_PROGRESSIVE]; // see [RQ6]
    end
  end

  // Resize and overlay not checked against each other: driver's job
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resize_act <= 1'b0;
      range_map_act <= 1'b0;
      chroma_conv_h_act <= 1'b0;
      chroma_conv_v_act <= 1'b0;
      menu_overlay_act <= 1'b0;
    end else if (launch) begin
      resize_act <= pwdata[BIT_RESIZE] & mode_active(wmode); // see [RQ10]
      range_map_act <= pwdata[BIT_RANGE_MAP] & mode_odd(wmode); // see [RQ9]
      chroma_conv_h_act <= pwdata[BIT_CHROMA_CONV] &
                           mode_active(wmode); // see [RQ11]
      chroma_conv_v_act <= mode_active(wmode); // see [RQ11]
      menu_overlay_act <= pwdata[BIT_MENU_OVERLAY] &
                          mode_odd(wmode); // see [RQ8]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overlay_src_fmt_act <= 1'b0;
      video_src_fmt_act <= 1'b0;
      result_fmt_act <= 1'b0;
    end else if (launch) begin
      overlay_src_fmt_act <= pwdata[BIT_OVERLAY_FMT]; // see [RQ14]
      video_src_fmt_act <= pwdata[BIT_VIDEO_FMT]; // see [RQ14]
      result_fmt_act <= pwdata[BIT_RESULT_FMT]; // see [RQ14]
    end
  end

  // ----------------------------------------------------------------
  // Interrupt enable and arming
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_enable_bit <= 1'b0;
    end else if (wr_enable) begin
      irq_enable_bit <= pwdata[BIT_IRQ_FLAG];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_arm_bit <= 1'b0;
    end else if (!irq_enable_bit) begin
      irq_arm_bit <= 1'b0; // see [RQ17]
    end else if (wr_arm && pwdata[BIT_IRQ_FLAG]) begin
      irq_arm_bit <= 1'b1; // see [RQ17]
    end else if (wr_disarm && pwdata[BIT_IRQ_FLAG] && irq_arm_bit) begin
      irq_arm_bit <= 1'b0; // see [RQ19]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_pulse <= 1'b0;
    end else begin
      irq_pulse <= done_evt & irq_enable_bit & irq_arm_bit; // see [RQ18]
    end
  end

  // ----------------------------------------------------------------
  // Frame status
  // ----------------------------------------------------------------
  // Completion wins over a clear landing in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_done_flag <= 1'b0;
    end else if (done_evt) begin
      frame_done_flag <= 1'b1; // see [RQ22]
    end else if (launch) begin
      frame_done_flag <= 1'b0; // see [RQ20]
    end else if (wr_stclr && pwdata[BIT_IRQ_FLAG]) begin
      frame_done_flag <= 1'b0; // see [RQ21]
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_start_busy;
    launch |=> frame_launch && busy ##1 state == ENG_RUN;
  endproperty
  a_start_busy: assert property (p_start_busy) // see [RQ1]
    else $error("start did not make the engine busy");

  property p_no_relaunch;
    busy && wr_ctrl && !done_evt |=> !frame_launch && busy;
  endproperty
  a_no_relaunch: assert property (p_no_relaunch) // see [RQ2]
    else $error("busy write disturbed the start bit");

  property p_chroma_sample;
    launch |=> chroma_proc_act == $past(pwdata[BIT_CHROMA_PROC]);
  endproperty
  a_chroma_sample: assert property (p_chroma_sample) // see [RQ3]
    else $error("chroma enable not sampled at start");

  property p_luma_hold;
    !launch |=> $stable(luma_proc_act);
  endproperty
  a_luma_hold: assert property (p_luma_hold) // see [RQ4]
    else $error("luma enable changed during a frame");

  property p_fields_interlaced;
    progressive_act |-> !top_field_act && !bottom_field_act;
  endproperty
  a_fields_interlaced: assert property (p_fields_interlaced) // see [RQ6]
    else $error("field enable active in progressive frame");

  property p_mode_sample;
    launch |=> flow_mode_act == $past(wmode);
  endproperty
  a_mode_sample: assert property (p_mode_sample) // see [RQ7]
    else $error("flow mode not captured at start");

  property p_overlay_mode;
    menu_overlay_act |-> mode_odd(flow_mode_act);
  endproperty
  a_overlay_mode: assert property (p_overlay_mode) // see [RQ8]
    else $error("overlay active in a mode that ignores it");

  property p_range_mode;
    range_map_act |-> mode_odd(flow_mode_act);
  endproperty
  a_range_mode: assert property (p_range_mode) // see [RQ9]
    else $error("range mapping active in a mode that ignores it");

  property p_resize_mode;
    resize_act || chroma_conv_h_act |-> mode_active(flow_mode_act);
  endproperty
  a_resize_mode: assert property (p_resize_mode) // see [RQ10]
    else $error("resize or chroma conversion active in mode 0");

  property p_arm_gated;
    !irq_enable_bit |=> !irq_arm_bit;
  endproperty
  a_arm_gated: assert property (p_arm_gated) // see [RQ17]
    else $error("arm bit set while interrupts disabled");

  property p_irq_once;
    done_evt && irq_enable_bit && irq_arm_bit |=> irq_pulse ##1 !irq_pulse;
  endproperty
  a_irq_once: assert property (p_irq_once) // see [RQ18]
    else $error("frame end gave no single interrupt pulse");

  property p_disarm;
    wr_disarm && pwdata[BIT_IRQ_FLAG] && irq_arm_bit |=> !irq_arm_bit;
  endproperty
  a_disarm: assert property (p_disarm) // see [RQ19]
    else $error("disarm write did not clear the arm bit");

  property p_done_idle;
    done_evt |=> frame_done_flag && !busy;
  endproperty
  a_done_idle: assert property (p_done_idle) // see [RQ22]
    else $error("done and idle not shown together");

  property p_status_running;
    state == ENG_RUN |-> !frame_done_flag;
  endproperty
  a_status_running: assert property (p_status_running) // see [RQ20]
    else $error("status set while a frame runs");

  property p_status_clear;
    wr_stclr && pwdata[BIT_IRQ_FLAG] && !done_evt |=> !frame_done_flag;
  endproperty
  a_status_clear: assert property (p_status_clear) // see [RQ21]
    else $error("status clear write did not clear status");

endmodule : video_convert_ctrl_irq_regs
`default_nettype wire

// *** logic/video_convert_pkg.sv ***
`default_nettype none
package video_convert_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_ENGINE_CONTROL = 12'h004;
  localparam logic [11:0] OFS_IRQ_ENABLE = 12'h008;
  localparam logic [11:0] OFS_IRQ_ARM_SET = 12'h00C;
  localparam logic [11:0] OFS_IRQ_ARM_CLEAR = 12'h010;
  localparam logic [11:0] OFS_IRQ_FRAME_STATUS = 12'h014;
  localparam logic [11:0] OFS_IRQ_STATUS_CLEAR = 12'h018;

  // ----------------------------------------------------------------
  // Control field positions
  // ----------------------------------------------------------------
  localparam int BIT_FRAME_START = 0;
  localparam int BIT_LUMA_PROC = 1;
  localparam int BIT_CHROMA_PROC = 2;
  localparam int BIT_MODE_LO = 4;
  localparam int BIT_MODE_HI = 5;
  localparam int BIT_BOTTOM_FIELD = 6;
  localparam int BIT_TOP_FIELD = 7;
  localparam int BIT_RESIZE = 8;
  localparam int BIT_RANGE_MAP = 9;
  localparam int BIT_CHROMA_CONV = 10;
  localparam int BIT_MENU_OVERLAY = 11;
  localparam int BIT_PROGRESSIVE = 12;
  localparam int BIT_RESULT_FMT = 13;
  localparam int BIT_VIDEO_FMT = 14;
  localparam int BIT_OVERLAY_FMT = 15;
  localparam int BIT_IRQ_FLAG = 0;

  // ----------------------------------------------------------------
  // Reset values and masks
  // ----------------------------------------------------------------
  localparam logic [15:0] CTRL_CFG_MASK = 16'hFFF6;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FLOW_EDGE_PAD = 2'h0,
    FLOW_TRANS_CODE = 2'h1,
    FLOW_PRE_CODEC = 2'h2,
    FLOW_POST_CODEC = 2'h3
  } flow_mode_t;

  typedef enum logic [1:0] {
    ENG_IDLE = 2'b00,
    ENG_LAUNCH = 2'b01,
    ENG_RUN = 2'b11
  } engine_state_t;

endpackage : video_convert_pkg
`default_nettype wire

// *** sim/video_convert_ctrl_irq_regs_tb_top.sv ***
`default_nettype none
module video_convert_ctrl_irq_regs_tb_top
  import video_convert_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata;
  logic pready;
  logic [DATA_W-1:0] prdata;
  logic pslverr;
  logic frame_finished;
  logic frame_launch;
  logic luma_proc_act;
  logic chroma_proc_act;
  logic top_field_act;
  logic bottom_field_act;
  logic [1:0] flow_mode_act;
  logic resize_act;
  logic range_map_act;
  logic chroma_conv_h_act;
  logic chroma_conv_v_act;
  logic menu_overlay_act;
  logic progressive_act;
  logic overlay_src_fmt_act;
  logic video_src_fmt_act;
  logic result_fmt_act;
  logic irq_pulse;
  logic [14:0] act_vec;
  int miscompares;
  int comparisons;
  int pulses;
  int launches;

  assign act_vec = {luma_proc_act, chroma_proc_act, top_field_act,
    bottom_field_act, flow_mode_act, resize_act, range_map_act,
    chroma_conv_h_act, chroma_conv_v_act, menu_overlay_act,
    progressive_act, overlay_src_fmt_act, video_src_fmt_act,
    result_fmt_act};

  video_convert_ctrl_irq_regs u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .frame_finished(frame_finished),
    .frame_launch(frame_launch), .luma_proc_act(luma_proc_act),
    .chroma_proc_act(chroma_proc_act), .top_field_act(top_field_act),
    .bottom_field_act(bottom_field_act), .flow_mode_act(flow_mode_act),
    .resize_act(resize_act), .range_map_act(range_map_act),
    .chroma_conv_h_act(chroma_conv_h_act),
    .chroma_conv_v_act(chroma_conv_v_act),
    .menu_overlay_act(menu_overlay_act), .progressive_act(progressive_act),
    .overlay_src_fmt_act(overlay_src_fmt_act),
    .video_src_fmt_act(video_src_fmt_act), .result_fmt_act(result_fmt_act),
    .irq_pulse(irq_pulse)
  );

  // ----------------------------------------------------------------
  // Clock and event counters
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // Pulses counted over a window, so exact cycle of arrival is free
  always @(posedge pclk) begin
    if (irq_pulse === 1'b1) pulses++;
    if (frame_launch === 1'b1) launches++;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic close_out();
    if (miscompares == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    bit done;
    done = 1'b0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (int n = 0; n < 16 && !done; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) done = 1'b1;
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (!done) begin
      miscompares++;
      close_out();
    end
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : wr

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0000_0000, q, e);
    check(q, exp);
  endtask : rd_chk

  function automatic logic [14:0] exp_act(input logic [15:0] c);
    logic [1:0] m;
    logic pr;
    m = c[5:4];
    pr = c[12];
    return {c[1], c[2], c[7] & ~pr, c[6] & ~pr, m, c[8] & (m != 2'h0),
      c[9] & m[0], c[10] & (m != 2'h0), m != 2'h0, c[11] & m[0], pr,
      c[15], c[14], c[13]};
  endfunction : exp_act

  // One frame: launch, disturb while busy, finish, count irq pulses
  task automatic do_frame(input logic [15:0] c, input int exp_pulses);
    int p0;
    int l0;
    logic [31:0] cfg;
    logic [31:0] alt;
    p0 = pulses;
    l0 = launches;
    cfg = {16'h0000, c & CTRL_CFG_MASK};
    alt = {16'h0000, (c ^ 16'h0006) & CTRL_CFG_MASK};
    wr(OFS_ENGINE_CONTROL, cfg | 32'h0000_0001);
    #1;
    check(act_vec, exp_act(c));
    rd_chk(OFS_ENGINE_CONTROL, cfg | 32'h0000_0001);
    rd_chk(OFS_IRQ_FRAME_STATUS, 32'h0000_0000);
    wr(OFS_ENGINE_CONTROL, alt);
    rd_chk(OFS_ENGINE_CONTROL, alt | 32'h0000_0001);
    wr(OFS_ENGINE_CONTROL, alt | 32'h0000_0001);
    check(launches - l0, 1);
    check(act_vec, exp_act(c));
    @(posedge pclk);
    frame_finished <= 1'b1;
    @(posedge pclk);
    frame_finished <= 1'b0;
    rd_chk(OFS_ENGINE_CONTROL, alt);
    rd_chk(OFS_IRQ_FRAME_STATUS, 32'h0000_0001);
    repeat (3) @(posedge pclk);
    check(pulses - p0, exp_pulses);
  endtask : do_frame

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  // Resize and overlay never set together; one lane and field always on
  logic [15:0] pats [3] = '{16'hA782, 16'h50C4, 16'h0846};
  logic [11:0] regs [6] = '{OFS_ENGINE_CONTROL, OFS_IRQ_ENABLE,
    OFS_IRQ_ARM_SET, OFS_IRQ_ARM_CLEAR, OFS_IRQ_FRAME_STATUS,
    OFS_IRQ_STATUS_CLEAR};

  initial begin
    logic [31:0] q;
    logic e;
    miscompares = 0;
    comparisons = 0;
    pulses = 0;
    launches = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    frame_finished = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    foreach (regs[i]) rd_chk(regs[i], 32'h0000_0000);
    apb(1'b0, 12'h000, 32'h0000_0000, q, e);
    check(e, 1);
    check(q, 32'h0000_0000);
    apb(1'b1, 12'hFFC, 32'hFFFF_FFFF, q, e);
    check(e, 1);
    wr(OFS_ENGINE_CONTROL, 32'hFFFF_FFF6);
    rd_chk(OFS_ENGINE_CONTROL, 32'h0000_FFF6);
    wr(OFS_ENGINE_CONTROL, 32'h0000_0000);
    // Finish report while idle must not mark a frame done
    @(posedge pclk);
    frame_finished <= 1'b1;
    @(posedge pclk);
    frame_finished <= 1'b0;
    rd_chk(OFS_IRQ_FRAME_STATUS, 32'h0000_0000);
    wr(OFS_IRQ_ARM_SET, 32'h0000_0001);
    rd_chk(OFS_IRQ_ARM_SET, 32'h0000_0000);
    wr(OFS_IRQ_ENABLE, 32'h0000_0001);
    rd_chk(OFS_IRQ_ENABLE, 32'h0000_0001);
    wr(OFS_IRQ_ARM_SET, 32'h0000_0000);
    rd_chk(OFS_IRQ_ARM_SET, 32'h0000_0000);
    wr(OFS_IRQ_ARM_SET, 32'h0000_0001);
    rd_chk(OFS_IRQ_ARM_SET, 32'h0000_0001);
    foreach (pats[i]) begin
      for (int m = 0; m < 4; m++) begin
        do_frame(pats[i] | 16'(m << 4), 1);
      end
    end
    wr(OFS_IRQ_STATUS_CLEAR, 32'h0000_0000);
    rd_chk(OFS_IRQ_FRAME_STATUS, 32'h0000_0001);
    wr(OFS_IRQ_FRAME_STATUS, 32'h0000_0000);
    rd_chk(OFS_IRQ_FRAME_STATUS, 32'h0000_0001);
    wr(OFS_IRQ_STATUS_CLEAR, 32'h0000_0001);
    rd_chk(OFS_IRQ_FRAME_STATUS, 32'h0000_0000);
    rd_chk(OFS_IRQ_STATUS_CLEAR, 32'h0000_0000);
    wr(OFS_IRQ_ARM_CLEAR, 32'h0000_0000);
    rd_chk(OFS_IRQ_ARM_SET, 32'h0000_0001);
    wr(OFS_IRQ_ARM_CLEAR, 32'h0000_0001);
    rd_chk(OFS_IRQ_ARM_SET, 32'h0000_0000);
    rd_chk(OFS_IRQ_ARM_CLEAR, 32'h0000_0000);
    // Overlay sources for this frame are given as progressive data
    do_frame(16'h0856, 0);
    wr(OFS_IRQ_ARM_SET, 32'h0000_0001);
    wr(OFS_IRQ_ENABLE, 32'h0000_0000);
    rd_chk(OFS_IRQ_ARM_SET, 32'h0000_0000);
    wr(OFS_IRQ_ARM_CLEAR, 32'h0000_0001);
    wr(OFS_IRQ_ENABLE, 32'h0000_0001);
    rd_chk(OFS_IRQ_ARM_SET, 32'h0000_0000);
    do_frame(16'hA7B2, 0);
    close_out();
  end

endmodule : video_convert_ctrl_irq_regs_tb_top
`default_nettype wire
